// *** inc/port_a_mux_defines.svh ***
// Constants for the port A pad function multiplexer
//
// Contract
// - Each pad i has a 3-bit read-write selector at bit 4*i of the function select register, reset 0x0.
// - Selector 0x0 makes the pad a general IO bit whose output enable is the GPIO direction bit.
// - Pad 7 routes master transmit from pad, UART single wire, UART receive, slave stage 1, debug 7, slave receive, PWM 2.
// - Pad 6 routes slave transmit from pad, UART single wire, UART transmit, slave PHY, debug 6, slave core transmit, PWM 1.
// - Pad 5 routes slave core receive, UART receive, SPI MISO, master core receive, master stage 1, debug 5, PWM 0.
// - Pad 4 routes slave stage 3, UART transmit, SPI MOSI, master stage 3, master PHY, debug 4, PWM 4.
// - Pad 3 routes slave stage 2, SPI MISO, debug 3, master stage 2, slave stage 3, master receive from pad, PWM 3.
// - Pad 2 routes slave stage 1, SPI MOSI, SPI select, debug 2, slave stage 2, master core transmit, PWM 2.
// - Pad 1 routes debug 1, SPI clock on two codes, master stage 1, slave stage 1, slave receive from pad, PWM 1.
// - Pad 0 routes slave PHY on two codes, SPI select, debug 0, master PHY, slave core transmit, PWM 0.
// - A debug line reaches a pad only while debug access is enabled.
// - The pad control register holds read enables at bit 16, pull-downs at bit 8 and pull-ups at bit 0, reset zero.
`ifndef PORT_A_MUX_DEFINES_SVH
`define PORT_A_MUX_DEFINES_SVH

// ------------------------------------------------------------
// Register addresses
// ------------------------------------------------------------
`define PAM_ADDR_FSEL_A 32'h5000_0C00
`define PAM_ADDR_FSEL_B 32'h5000_0C04
`define PAM_ADDR_CTRL_A 32'h5000_0C08
`define PAM_ADDR_CTRL_B 32'h5000_0C0C

// ------------------------------------------------------------
// Field layout
// ------------------------------------------------------------
`define PAM_PADS        8
`define PAM_SEL_W       3
`define PAM_SEL_STRIDE  4
`define PAM_RE_POS      16
`define PAM_PD_POS      8
`define PAM_PU_POS      0
`define PAM_A_FIELD_W   8
`define PAM_B_FIELD_W   4
`define PAM_PWM_CH      5

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define PAM_SEL_RST     3'h0
`define PAM_A_FIELD_RST 8'h00
`define PAM_B_FIELD_RST 4'h0
`define PAM_FSEL_B_RST  32'h0000_0000

`endif

// *** inc/port_a_mux_pkg.sv ***
// Types shared by the port A pad function multiplexer
`include "port_a_mux_defines.svh"

package port_a_mux_pkg;

  // ------------------------------------------------------------
  // Pad-side control fields
  // ------------------------------------------------------------
  typedef struct packed {
    logic [`PAM_A_FIELD_W-1:0] re;
    logic [`PAM_A_FIELD_W-1:0] pd;
    logic [`PAM_A_FIELD_W-1:0] pu;
  } pad_ctrl_a_t;

  typedef struct packed {
    logic [`PAM_B_FIELD_W-1:0] re;
    logic [`PAM_B_FIELD_W-1:0] pd;
    logic [`PAM_B_FIELD_W-1:0] pu;
  } pad_ctrl_b_t;

  // ------------------------------------------------------------
  // Signals that peripherals offer to the pads
  // ------------------------------------------------------------
  typedef struct packed {
    logic [`PAM_PADS-1:0]   gpio_out;
    logic [`PAM_PADS-1:0]   gpio_dir;
    logic                   uart_txd;
    logic                   uart_sw_txd;
    logic                   uart_sw_oe;
    logic                   spi_sck;
    logic                   spi_sck_oe;
    logic                   spi_mosi;
    logic                   spi_mosi_oe;
    logic                   spi_miso;
    logic                   spi_miso_oe;
    logic                   spi_ss;
    logic                   spi_ss_oe;
    logic                   ms_tx_core;
    logic                   sl_tx_core;
    logic                   ms_phy_rx;
    logic                   sl_phy_rx;
    logic [2:0]             ms_stage;
    logic [2:0]             sl_stage;
    logic [`PAM_PWM_CH-1:0] pwm_aux;
    logic [`PAM_PADS-1:0]   debug_line;
  } pad_drive_t;

  // ------------------------------------------------------------
  // Signals that pads hand back to peripherals
  // ------------------------------------------------------------
  typedef struct packed {
    logic [`PAM_PADS-1:0] gpio_in;
    logic                 uart_rxd;
    logic                 uart_sw_rxd;
    logic                 spi_sck;
    logic                 spi_mosi;
    logic                 spi_miso;
    logic                 spi_ss;
    logic                 ms_tx_from_pad;
    logic                 sl_tx_from_pad;
    logic                 ms_core_rx;
    logic                 sl_core_rx;
    logic                 ms_rx_ext;
    logic                 sl_rx_ext;
  } pad_sink_t;

  typedef enum logic [3:0] {
    SNK_NONE,
    SNK_UART_RX,
    SNK_UART_SW,
    SNK_SPI_SCK,
    SNK_SPI_MOSI,
    SNK_SPI_MISO,
    SNK_SPI_SS,
    SNK_MS_TXG,
    SNK_SL_TXG,
    SNK_MS_CORE_RX,
    SNK_SL_CORE_RX,
    SNK_MS_RXE,
    SNK_SL_RXE
  } sink_t;

endpackage : port_a_mux_pkg

// *** src/port_a_pin_function_mux.sv ***
// Port A pad function multiplexer with its register file
`timescale 1ns/1ps

module port_a_pin_function_mux
  import port_a_mux_pkg::*;
(
  // Clock, reset and enable
  input  wire logic        i_clk,
  input  wire logic        i_rstn,
  input  wire logic        i_ce,
  // Register port
  input  wire logic [31:0] i_addr,
  input  wire logic [31:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic      [31:0] o_rdata,
  // System control
  input  wire logic        i_debug_enabled,
  // Peripheral side
  input  wire pad_drive_t  i_drive,
  output pad_sink_t        o_sink,
  // Pads
  input  wire logic [7:0]  i_pad_in,
  output logic      [7:0]  o_pad_out,
  output logic      [7:0]  o_pad_oe,
  output logic      [7:0]  o_pad_re,
  output logic      [7:0]  o_pad_pd,
  output logic      [7:0]  o_pad_pu,
  output logic      [3:0]  o_portb_re,
  output logic      [3:0]  o_portb_pd,
  output logic      [3:0]  o_portb_pu
);

  // ------------------------------------------------------------
  // Reset release
  // ------------------------------------------------------------
  logic rst_meta;
  logic rst_sync;

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rst_meta <= 1'b0;
      rst_sync <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_sync <= rst_meta;
    end
  end

  // ------------------------------------------------------------
  // Output route per pad and selector, as {oe, out}
  // ------------------------------------------------------------
  function automatic logic [1:0] route(
    input int unsigned pad,
    input logic [2:0]  sel,
    input pad_drive_t  d,
    input logic        dbg
  );
    logic [1:0] r;
    logic [1:0] tm;
    r  = {d.gpio_dir[pad], d.gpio_out[pad]};
    // Debug lines stay off the pad unless debug access is open
    tm = {dbg, dbg & d.debug_line[pad]};
    case (pad)
      7: begin
        case (sel)
          3'h1:    r = 2'b00;
          3'h2:    r = {d.uart_sw_oe, d.uart_sw_txd};
          3'h3:    r = 2'b00;
          3'h4:    r = {1'b1, d.sl_stage[0]};
          3'h5:    r = tm;
          3'h6:    r = 2'b00;
          3'h7:    r = {1'b1, d.pwm_aux[2]};
          default: r = r;
        endcase
      end
      6: begin
        case (sel)
          3'h1:    r = 2'b00;
          3'h2:    r = {d.uart_sw_oe, d.uart_sw_txd};
          3'h3:    r = {1'b1, d.uart_txd};
          3'h4:    r = {1'b1, d.sl_phy_rx};
          3'h5:    r = tm;
          3'h6:    r = {1'b1, d.sl_tx_core};
          3'h7:    r = {1'b1, d.pwm_aux[1]};
          default: r = r;
        endcase
      end
      5: begin
        case (sel)
          3'h1:    r = 2'b00;
          3'h2:    r = 2'b00;
          3'h3:    r = {d.spi_miso_oe, d.spi_miso};
          3'h4:    r = 2'b00;
          3'h5:    r = {1'b1, d.ms_stage[0]};
          3'h6:    r = tm;
          3'h7:    r = {1'b1, d.pwm_aux[0]};
          default: r = r;
        endcase
      end
      4: begin
        case (sel)
          3'h1:    r = {1'b1, d.sl_stage[2]};
          3'h2:    r = {1'b1, d.uart_txd};
          3'h3:    r = {d.spi_mosi_oe, d.spi_mosi};
          3'h4:    r = {1'b1, d.ms_stage[2]};
          3'h5:    r = {1'b1, d.ms_phy_rx};
          3'h6:    r = tm;
          3'h7:    r = {1'b1, d.pwm_aux[4]};
          default: r = r;
        endcase
      end
      3: begin
        case (sel)
          3'h1:    r = {1'b1, d.sl_stage[1]};
          3'h2:    r = {d.spi_miso_oe, d.spi_miso};
          3'h3:    r = tm;
          3'h4:    r = {1'b1, d.ms_stage[1]};
          3'h5:    r = {1'b1, d.sl_stage[2]};
          3'h6:    r = 2'b00;
          3'h7:    r = {1'b1, d.pwm_aux[3]};
          default: r = r;
        endcase
      end
      2: begin
        case (sel)
          3'h1:    r = {1'b1, d.sl_stage[0]};
          3'h2:    r = {d.spi_mosi_oe, d.spi_mosi};
          3'h3:    r = {d.spi_ss_oe, d.spi_ss};
          3'h4:    r = tm;
          3'h5:    r = {1'b1, d.sl_stage[1]};
          3'h6:    r = {1'b1, d.ms_tx_core};
          3'h7:    r = {1'b1, d.pwm_aux[2]};
          default: r = r;
        endcase
      end
      1: begin
        case (sel)
          3'h1:    r = tm;
          3'h2:    r = {d.spi_sck_oe, d.spi_sck};
          3'h3:    r = {d.spi_sck_oe, d.spi_sck};
          3'h4:    r = {1'b1, d.ms_stage[0]};
          3'h5:    r = {1'b1, d.sl_stage[0]};
          3'h6:    r = 2'b00;
          3'h7:    r = {1'b1, d.pwm_aux[1]};
          default: r = r;
        endcase
      end
      default: begin
        case (sel)
          3'h1:    r = {1'b1, d.sl_phy_rx};
          3'h2:    r = {d.spi_ss_oe, d.spi_ss};
          3'h3:    r = tm;
          3'h4:    r = {1'b1, d.ms_phy_rx};
          3'h5:    r = {1'b1, d.sl_phy_rx};
          3'h6:    r = {1'b1, d.sl_tx_core};
          3'h7:    r = {1'b1, d.pwm_aux[0]};
          default: r = r;
        endcase
      end
    endcase
    return r;
  endfunction : route

  // ------------------------------------------------------------
  // Which peripheral input a pad feeds
  // ------------------------------------------------------------
  function automatic sink_t sink_of(
    input int unsigned pad,
    input logic [2:0]  sel
  );
    sink_t s;
    s = SNK_NONE;
    case ({pad[2:0], sel})
      {3'd7, 3'h1}: s = SNK_MS_TXG;
      {3'd7, 3'h2}: s = SNK_UART_SW;
      {3'd7, 3'h3}: s = SNK_UART_RX;
      {3'd7, 3'h6}: s = SNK_SL_RXE;
      {3'd6, 3'h1}: s = SNK_SL_TXG;
      {3'd6, 3'h2}: s = SNK_UART_SW;
      {3'd5, 3'h1}: s = SNK_SL_CORE_RX;
      {3'd5, 3'h2}: s = SNK_UART_RX;
      {3'd5, 3'h3}: s = SNK_SPI_MISO;
      {3'd5, 3'h4}: s = SNK_MS_CORE_RX;
      {3'd4, 3'h3}: s = SNK_SPI_MOSI;
      {3'd3, 3'h2}: s = SNK_SPI_MISO;
      {3'd3, 3'h6}: s = SNK_MS_RXE;
      {3'd2, 3'h2}: s = SNK_SPI_MOSI;
      {3'd2, 3'h3}: s = SNK_SPI_SS;
      {3'd1, 3'h2}: s = SNK_SPI_SCK;
      {3'd1, 3'h3}: s = SNK_SPI_SCK;
      {3'd1, 3'h6}: s = SNK_SL_RXE;
      {3'd0, 3'h2}: s = SNK_SPI_SS;
      default:      s = SNK_NONE;
    endcase
    return s;
  endfunction : sink_of

  // ------------------------------------------------------------
  // Register file
  // ------------------------------------------------------------
  logic [7:0][2:0] fsel;
  logic [7:0][2:0] next_fsel;
  logic [31:0]     fsel_b;
  logic [31:0]     next_fsel_b;
  pad_ctrl_a_t     ctrl_a;
  pad_ctrl_a_t     next_ctrl_a;
  pad_ctrl_b_t     ctrl_b;
  pad_ctrl_b_t     next_ctrl_b;
  logic [31:0]     next_rdata;
  logic [31:0]     fsel_word;

  always_comb begin
    next_fsel   = fsel;
    next_fsel_b = fsel_b;
    next_ctrl_a = ctrl_a;
    next_ctrl_b = ctrl_b;
    next_rdata  = 32'h0000_0000;
    fsel_word   = 32'h0000_0000;
    for (int i = 0; i < `PAM_PADS; i++) begin
      fsel_word[`PAM_SEL_STRIDE*i +: `PAM_SEL_W] = fsel[i];
    end
    if (i_wr) begin
      case (i_addr)
        `PAM_ADDR_FSEL_A: begin
          for (int i = 0; i < `PAM_PADS; i++) begin
            next_fsel[i] = i_wdata[`PAM_SEL_STRIDE*i +: `PAM_SEL_W];
          end
        end
        `PAM_ADDR_FSEL_B: next_fsel_b = i_wdata;
        `PAM_ADDR_CTRL_A: begin
          next_ctrl_a.re = i_wdata[`PAM_RE_POS +: `PAM_A_FIELD_W];
          next_ctrl_a.pd = i_wdata[`PAM_PD_POS +: `PAM_A_FIELD_W];
          next_ctrl_a.pu = i_wdata[`PAM_PU_POS +: `PAM_A_FIELD_W];
        end
        `PAM_ADDR_CTRL_B: begin
          next_ctrl_b.re = i_wdata[`PAM_RE_POS +: `PAM_B_FIELD_W];
          next_ctrl_b.pd = i_wdata[`PAM_PD_POS +: `PAM_B_FIELD_W];
          next_ctrl_b.pu = i_wdata[`PAM_PU_POS +: `PAM_B_FIELD_W];
        end
        default: next_fsel_b = fsel_b;
      endcase
    end
    // Unmapped reads answer zero; read data lives for one cycle only
    if (i_rd) begin
      case (i_addr)
        `PAM_ADDR_FSEL_A: next_rdata = fsel_word;
        `PAM_ADDR_FSEL_B: next_rdata = fsel_b;
        `PAM_ADDR_CTRL_A: begin
          next_rdata[`PAM_RE_POS +: `PAM_A_FIELD_W] = ctrl_a.re;
          next_rdata[`PAM_PD_POS +: `PAM_A_FIELD_W] = ctrl_a.pd;
          next_rdata[`PAM_PU_POS +: `PAM_A_FIELD_W] = ctrl_a.pu;
        end
        `PAM_ADDR_CTRL_B: begin
          next_rdata[`PAM_RE_POS +: `PAM_B_FIELD_W] = ctrl_b.re;
          next_rdata[`PAM_PD_POS +: `PAM_B_FIELD_W] = ctrl_b.pd;
          next_rdata[`PAM_PU_POS +: `PAM_B_FIELD_W] = ctrl_b.pu;
        end
        default: next_rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge rst_sync) begin
    if (!rst_sync) begin
      fsel    <= {`PAM_PADS{`PAM_SEL_RST}};
      fsel_b  <= `PAM_FSEL_B_RST;
      ctrl_a  <= {3{`PAM_A_FIELD_RST}};
      ctrl_b  <= {3{`PAM_B_FIELD_RST}};
      o_rdata <= 32'h0000_0000;
    end else if (i_ce) begin
      fsel    <= next_fsel;
      fsel_b  <= next_fsel_b;
      ctrl_a  <= next_ctrl_a;
      ctrl_b  <= next_ctrl_b;
      o_rdata <= next_rdata;
    end
  end

  // ------------------------------------------------------------
  // Pad drive and peripheral inputs
  // ------------------------------------------------------------
  logic [7:0] next_pad_out;
  logic [7:0] next_pad_oe;
  pad_sink_t  next_sink;

  always_comb begin
    logic [1:0] rt;
    next_pad_out = 8'h00;
    next_pad_oe  = 8'h00;
    next_sink    = '0;
    rt           = 2'b00;
    for (int i = 0; i < `PAM_PADS; i++) begin
      // Output-only taps force the enable high, debug taps take it from debug access, receive paths force it low
      rt              = route(i, fsel[i], i_drive, i_debug_enabled);
      next_pad_oe[i]  = rt[1];
      next_pad_out[i] = rt[0];
      // GPIO sees its pad only through the read enable
      next_sink.gpio_in[i] = i_pad_in[i] & ctrl_a.re[i];
      // Several pads on one input are ORed; software avoids that
      case (sink_of(i, fsel[i]))
        SNK_UART_RX:    next_sink.uart_rxd       |= i_pad_in[i];
        SNK_UART_SW:    next_sink.uart_sw_rxd    |= i_pad_in[i];
        SNK_SPI_SCK:    next_sink.spi_sck        |= i_pad_in[i];
        SNK_SPI_MOSI:   next_sink.spi_mosi       |= i_pad_in[i];
        SNK_SPI_MISO:   next_sink.spi_miso       |= i_pad_in[i];
        SNK_SPI_SS:     next_sink.spi_ss         |= i_pad_in[i];
        SNK_MS_TXG:     next_sink.ms_tx_from_pad |= i_pad_in[i];
        SNK_SL_TXG:     next_sink.sl_tx_from_pad |= i_pad_in[i];
        SNK_MS_CORE_RX: next_sink.ms_core_rx     |= i_pad_in[i];
        SNK_SL_CORE_RX: next_sink.sl_core_rx     |= i_pad_in[i];
        SNK_MS_RXE:     next_sink.ms_rx_ext      |= i_pad_in[i];
        SNK_SL_RXE:     next_sink.sl_rx_ext      |= i_pad_in[i];
        default:        next_sink.uart_rxd       |= 1'b0;
      endcase
    end
  end

  // Registered pad side costs one cycle of latency on every path
  always_ff @(posedge i_clk or negedge rst_sync) begin
    if (!rst_sync) begin
      o_pad_out <= 8'h00;
      o_pad_oe  <= 8'h00;
      o_sink    <= '0;
    end else if (i_ce) begin
      o_pad_out <= next_pad_out;
      o_pad_oe  <= next_pad_oe;
      o_sink    <= next_sink;
    end
  end

  // Pad resistor and read controls come straight from their flops
  assign o_pad_re   = ctrl_a.re;
  assign o_pad_pd   = ctrl_a.pd;
  assign o_pad_pu   = ctrl_a.pu;
  assign o_portb_re = ctrl_b.re;
  assign o_portb_pd = ctrl_b.pd;
  assign o_portb_pu = ctrl_b.pu;

endmodule : port_a_pin_function_mux

// *** dv/port_a_mux_props.sv ***
// Port-level assertions for the port A pad function multiplexer
`timescale 1ns/1ps
`include "port_a_mux_defines.svh"

module port_a_mux_props
  import port_a_mux_pkg::*;
(
  // Clock and reset
  input wire logic        i_clk,
  input wire logic        i_rstn,
  // Register port
  input wire logic        i_ce,
  input wire logic [31:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic        i_wr,
  input wire logic        i_rd,
  input wire logic [31:0] o_rdata,
  // Pads and peripherals
  input wire logic        i_debug_enabled,
  input wire pad_drive_t  i_drive,
  input wire pad_sink_t   o_sink,
  input wire logic [7:0]  i_pad_in,
  input wire logic [7:0]  o_pad_out,
  input wire logic [7:0]  o_pad_oe,
  input wire logic [7:0]  o_pad_re,
  input wire logic [7:0]  o_pad_pd,
  input wire logic [7:0]  o_pad_pu
);
  // ----
  // Selector shadow
  // ----
  // Debug and PWM channel code per pad, pad 7 leftmost
  localparam logic [23:0] DBG_CODE = {3'h5, 3'h5, 3'h6, 3'h6, 3'h3, 3'h4, 3'h1, 3'h3};
  localparam logic [23:0] PWM_CH   = {3'h2, 3'h1, 3'h0, 3'h4, 3'h3, 3'h2, 3'h1, 3'h0};

  logic [31:0] fsel, next_fsel;
  logic [3:0]  run, next_run;
  logic [7:0]  gpio_sel, dbg_sel, pwm_sel, pwm_now;

  // Held off until the design's reset synchroniser has let go
  always_comb begin
    next_run  = {run[2:0], 1'b1};
    next_fsel = fsel;
    if (i_ce && i_wr && i_addr == `PAM_ADDR_FSEL_A) next_fsel = i_wdata & 32'h7777_7777;
    for (int i = 0; i < 8; i++) begin
      gpio_sel[i] = fsel[4*i+:3] == 3'h0;
      dbg_sel[i]  = fsel[4*i+:3] == DBG_CODE[3*i+:3];
      pwm_sel[i]  = fsel[4*i+:3] == 3'h7;
      pwm_now[i]  = i_drive.pwm_aux[PWM_CH[3*i+:3]];
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      run  <= 4'h0;
      fsel <= 32'h0000_0000;
    end else begin
      run  <= next_run;
      fsel <= next_fsel;
    end
  end

  // ----
  // Properties
  // ----
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!run[3]);

  sequence s_fsel_read;
    i_ce && i_rd && i_addr == `PAM_ADDR_FSEL_A;
  endsequence

  sequence s_ctrl_write;
    i_ce && i_wr && i_addr == `PAM_ADDR_CTRL_A;
  endsequence

  a_fsel_readback: assert property (s_fsel_read |=> o_rdata == $past(fsel))
    else $error("selector read data wrong");
  a_ctrl_write: assert property (s_ctrl_write |=> {o_pad_re, o_pad_pd, o_pad_pu} == $past(i_wdata[23:0]))
    else $error("pad control fields wrong after write");
  a_ctrl_hold: assert property (!(i_ce && i_wr && i_addr == `PAM_ADDR_CTRL_A) |=>
    $stable({o_pad_re, o_pad_pd, o_pad_pu}))
    else $error("pad control changed without write");
  a_gpio_path: assert property ($past(i_ce) |->
    ((o_pad_oe ^ $past(i_drive.gpio_dir)) & $past(gpio_sel)) == 8'h00 &&
    ((o_pad_out ^ $past(i_drive.gpio_out)) & $past(gpio_sel)) == 8'h00)
    else $error("general io pad not following its bit");
  a_debug_off: assert property ($past(i_ce && !i_debug_enabled) |-> (o_pad_oe & $past(dbg_sel)) == 8'h00)
    else $error("debug line driven while debug disabled");
  a_debug_on: assert property ($past(i_ce && i_debug_enabled) |->
    ((o_pad_out ^ $past(i_drive.debug_line)) & $past(dbg_sel)) == 8'h00)
    else $error("debug line not routed");
  a_pwm_route: assert property ($past(i_ce) |->
    ((o_pad_out ^ $past(pwm_now)) & $past(pwm_sel)) == 8'h00 && (o_pad_oe & $past(pwm_sel)) == $past(pwm_sel))
    else $error("pwm channel routed wrongly");
  a_slave_rx: assert property ($past(i_ce && fsel[22:20] == 3'h1) |->
    !o_pad_oe[5] && o_sink.sl_core_rx == $past(i_pad_in[5]))
    else $error("slave receive input path wrong");
endmodule : port_a_mux_props

bind port_a_pin_function_mux port_a_mux_props u_props (
  .i_clk(i_clk), .i_rstn(i_rstn), .i_ce(i_ce), .i_addr(i_addr), .i_wdata(i_wdata),
  .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_debug_enabled(i_debug_enabled),
  .i_drive(i_drive), .o_sink(o_sink), .i_pad_in(i_pad_in), .o_pad_out(o_pad_out),
  .o_pad_oe(o_pad_oe), .o_pad_re(o_pad_re), .o_pad_pd(o_pad_pd), .o_pad_pu(o_pad_pu)
);

// *** dv/periph_model.sv ***
// Pattern source standing in for the functions behind port A
`timescale 1ns/1ps

module periph_model
  import port_a_mux_pkg::*;
(
  // Clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_rstn,
  // Pattern choice
  input  wire logic [7:0] i_seed,
  // Signals offered to the pads
  output pad_drive_t      o_drive
);
  logic [55:0] pat;
  pad_drive_t  next_drive;

  // Every function but GPIO drives its pin, so a low enable away from the GPIO code is the mux's doing
  always_comb begin
    pat                    = {7{i_seed}};
    next_drive             = pat[$bits(pad_drive_t)-1:0];
    next_drive.gpio_dir    = i_seed;
    next_drive.gpio_out    = ~i_seed;
    next_drive.uart_sw_oe  = 1'b1;
    next_drive.spi_sck_oe  = 1'b1;
    next_drive.spi_mosi_oe = 1'b1;
    next_drive.spi_miso_oe = 1'b1;
    next_drive.spi_ss_oe   = 1'b1;
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_drive <= '0;
    end else begin
      o_drive <= next_drive;
    end
  end
endmodule : periph_model

// *** dv/tb_port_a_pin_function_mux.sv ***
// Self-checking bench for the port A pad function multiplexer
`timescale 1ns/1ps
`include "port_a_mux_defines.svh"

module tb_port_a_pin_function_mux
  import port_a_mux_pkg::*;
;
  logic        i_clk = 1'b0;
  logic        i_rstn = 1'b0;
  logic        i_ce = 1'b1;
  logic        i_wr = 1'b0;
  logic        i_rd = 1'b0;
  logic        i_debug_enabled = 1'b0;
  logic [31:0] i_addr = 32'h0000_0000;
  logic [31:0] i_wdata = 32'h0000_0000;
  logic [7:0]  i_pad_in = 8'h00;
  logic [7:0]  seed = 8'h00;
  logic [31:0] o_rdata;
  logic [7:0]  o_pad_out, o_pad_oe, o_pad_re, o_pad_pd, o_pad_pu, ex, eo;
  logic [3:0]  o_portb_re, o_portb_pd, o_portb_pu;
  pad_drive_t  d;
  pad_sink_t   o_sink;
  int          miscompares = 0;
  int          compares = 0;
  int          cycles = 0;
  // Pad enables per code 1..7 with debug on, and the pads that carry a debug line
  logic [7:0]  oe_tab [1:7] = '{8'h1F, 8'hDF, 8'h7F, 8'hDF, 8'hFF, 8'h75, 8'hFF};
  logic [7:0]  dbg_tab [1:7] = '{8'h02, 8'h00, 8'h09, 8'h04, 8'hC0, 8'h30, 8'h00};

  periph_model u_model (.i_clk(i_clk), .i_rstn(i_rstn), .i_seed(seed), .o_drive(d));

  port_a_pin_function_mux uut (
    .i_clk(i_clk), .i_rstn(i_rstn), .i_ce(i_ce), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_debug_enabled(i_debug_enabled),
    .i_drive(d), .o_sink(o_sink), .i_pad_in(i_pad_in), .o_pad_out(o_pad_out),
    .o_pad_oe(o_pad_oe), .o_pad_re(o_pad_re), .o_pad_pd(o_pad_pd), .o_pad_pu(o_pad_pu),
    .o_portb_re(o_portb_re), .o_portb_pd(o_portb_pd), .o_portb_pu(o_portb_pu)
  );

  always #10 i_clk = ~i_clk;

  // ----
  // Tasks
  // ----
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : print_verdict

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [31:0] a, input logic [31:0] v);
    @(posedge i_clk);
    i_wr    <= 1'b1;
    i_addr  <= a;
    i_wdata <= v;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [31:0] a, input logic [31:0] exp, input string what);
    @(posedge i_clk);
    i_rd   <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1;
    chk(o_rdata, exp, what);
  endtask : rd

  // Selector and pattern changes reach the pads two edges later
  task automatic settle();
    repeat (2) @(posedge i_clk);
    #1;
  endtask : settle

  // Run is about 120 cycles
  always @(posedge i_clk) begin
    cycles++;
    if (cycles > 3000) begin
      miscompares++;
      print_verdict();
    end
  end

  // ----
  // Tests
  // ----
  initial begin
    repeat (10) @(posedge i_clk);
    i_rstn <= 1'b1;
    repeat (4) @(posedge i_clk);
    rd(`PAM_ADDR_FSEL_A, 32'h0, "select reset");
    rd(`PAM_ADDR_CTRL_A, 32'h0, "control reset");
    wr(`PAM_ADDR_FSEL_A, 32'hFFFF_FFFF);
    rd(`PAM_ADDR_FSEL_A, 32'h7777_7777, "select width");
    wr(`PAM_ADDR_CTRL_A, 32'hFFFF_FFFF);
    rd(`PAM_ADDR_CTRL_A, 32'h00FF_FFFF, "control fields");
    chk(32'({o_pad_re, o_pad_pd, o_pad_pu}), 32'h00FF_FFFF, "control pins");
    wr(32'h5000_0C10, 32'hFFFF_FFFF);
    rd(32'h5000_0C10, 32'h0, "unmapped read");
    @(posedge i_clk);
    i_ce <= 1'b0;
    wr(`PAM_ADDR_FSEL_A, 32'h0);
    i_ce <= 1'b1;
    rd(`PAM_ADDR_FSEL_A, 32'h7777_7777, "frozen write");
    wr(`PAM_ADDR_CTRL_B, 32'hFFFF_FFFF);
    rd(`PAM_ADDR_CTRL_B, 32'h000F_0F0F, "port b control");
    chk(32'({o_portb_re, o_portb_pd, o_portb_pu}), 32'h0000_0FFF, "port b pins");
    wr(`PAM_ADDR_FSEL_B, 32'hA5A5_5A5A);
    rd(`PAM_ADDR_FSEL_B, 32'hA5A5_5A5A, "port b select");
    $display("register test done");
    wr(`PAM_ADDR_FSEL_A, 32'h0);
    wr(`PAM_ADDR_CTRL_A, 32'h000F_00C0);
    seed     <= 8'hA5;
    i_pad_in <= 8'h3C;
    settle();
    chk(32'(o_pad_oe), 32'(d.gpio_dir), "gpio enable");
    chk(32'(o_pad_out), 32'(d.gpio_out), "gpio out");
    chk(32'(o_sink.gpio_in), 32'h0C, "gpio in");
    $display("gpio test done");
    for (int s = 0; s < 2; s++) begin
      for (int c = 1; c < 8; c++) begin
        @(posedge i_clk);
        i_debug_enabled <= s[0];
        seed            <= s[0] ? 8'h3C : 8'hA5;
        i_pad_in        <= s[0] ? 8'h69 : 8'hA6;
        wr(`PAM_ADDR_FSEL_A, {8{1'b0, c[2:0]}});
        settle();
        eo = oe_tab[c] & ~(s[0] ? 8'h00 : dbg_tab[c]);
        case (c)
          1: ex = {3'h0, d.sl_stage, d.debug_line[1], d.sl_phy_rx};
          2: ex = {{2{d.uart_sw_txd}}, 1'b0, d.uart_txd, d.spi_miso, d.spi_mosi, d.spi_sck, d.spi_ss};
          3: ex = {1'b0, d.uart_txd, d.spi_miso, d.spi_mosi, d.debug_line[3], d.spi_ss, d.spi_sck, d.debug_line[0]};
          4: ex = {d.sl_stage[0], d.sl_phy_rx, 1'b0, d.ms_stage[2:1], d.debug_line[2], d.ms_stage[0], d.ms_phy_rx};
          5: ex = {d.debug_line[7:6], d.ms_stage[0], d.ms_phy_rx, d.sl_stage, d.sl_phy_rx};
          6: ex = {1'b0, d.sl_tx_core, d.debug_line[5:4], 1'b0, d.ms_tx_core, 1'b0, d.sl_tx_core};
          default: ex = {d.pwm_aux[2:0], d.pwm_aux[4:3], d.pwm_aux[2:0]};
        endcase
        chk(32'(o_pad_oe), 32'(eo), "pad enable");
        chk(32'(o_pad_out & oe_tab[c]), 32'(ex & eo), "pad out");
        chk(32'(o_sink.gpio_in), 32'(i_pad_in & 8'h0F), "gpio in");
        case (c)
          1: chk(32'({o_sink.ms_tx_from_pad, o_sink.sl_tx_from_pad, o_sink.sl_core_rx}), 32'(i_pad_in[7:5]), "lin in");
          2: chk(32'({o_sink.uart_rxd, o_sink.uart_sw_rxd}), 32'({i_pad_in[5], |i_pad_in[7:6]}), "uart in");
          3: chk(32'(o_sink.uart_rxd), 32'(i_pad_in[7]), "uart rx");
          4: chk(32'(o_sink.ms_core_rx), 32'(i_pad_in[5]), "master rx");
          6: chk(32'({o_sink.sl_rx_ext, o_sink.ms_rx_ext}), 32'({i_pad_in[7] | i_pad_in[1], i_pad_in[3]}), "ext rx");
          default: ;
        endcase
        $display("code %0d debug %0d test done", c, s);
      end
    end
    print_verdict();
  end
endmodule : tb_port_a_pin_function_mux
